// [verilog/nlg_cfg.svh]
// Purpose: Constants of the notch lookup and gain select block.
// Assumes: 32-bit classic Wishbone register access, 100 MHz clock.
// Notes: Offsets are byte addresses of aligned words.
`ifndef NLG_CFG_SVH
`define NLG_CFG_SVH

// ----------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------
`define NLG_ADDR_CTRL 4'h0
`define NLG_ADDR_STATUS 4'h4
`define NLG_ADDR_INDEX 4'h8
`define NLG_ADDR_NOTCH 4'hc

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define NLG_F_SW_EN 0
`define NLG_F_COND_LO 4
`define NLG_F_COND_HI 7
`define NLG_F_RIG_LO 8
`define NLG_F_RIG_HI 11
`define NLG_F_GAIN2 12
`define NLG_F_P_ONLY 13
`define NLG_F_NOTCH_EN 16

// ----------------------------------------------------------------------
// Reset values and ranges
// ----------------------------------------------------------------------
`define NLG_RST_SW_EN 1'h1
`define NLG_RST_COND 4'h0
`define NLG_RST_RIG 4'h2
`define NLG_COND_MAX 4'ha
`define NLG_IDX_FIRST 7'h05
`define NLG_IDX_LAST 7'h3b
`define NLG_IDX_MAX 7'h40
`define NLG_IDX_F_LO 7'h31
`define NLG_IDX_F_HI 7'h35
`define NLG_IDX_E_LO 7'h36
`define NLG_IDX_E_HI 7'h3a
`define NLG_RIG_F 4'hf
`define NLG_RIG_E 4'he
`define NLG_RIG_D 4'hd

// ----------------------------------------------------------------------
// Condition selector codes
// ----------------------------------------------------------------------
`define NLG_COND_GAIN1 4'h0
`define NLG_COND_GAIN2 4'h1
`define NLG_COND_INPUT 4'h2
`define NLG_COND_GAIN1_B 4'h4

`endif

// [verilog/nlg_pkg.sv]
// Purpose: Types shared by the notch lookup and gain select block.
// Assumes: Constants come from nlg_cfg.svh.
// Notes: Gain parameters are 16 bits each.
package nlg_pkg;

  typedef struct packed {
    logic [15:0] pos_loop;
    logic [15:0] speed_loop;
    logic [15:0] speed_integral;
    logic [15:0] speed_detect;
    logic [15:0] torque_filter;
  } nlg_gain_set_t;

  typedef struct packed {
    logic sw_en;
    logic [3:0] cond;
    logic [3:0] rigidity;
  } nlg_params_t;

  typedef struct packed {
    logic enable;
    logic [10:0] freq;
  } nlg_notch_t;

endpackage

// [verilog/nlg_notch_rom.sv]
// Purpose: Table index to notch frequency decode, rigidity qualified.
// Assumes: Index and rigidity are stable registered values.
// Notes: Purely combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none
`include "nlg_cfg.svh"

module nlg_notch_rom (
  input wire logic [6:0] index_i,
  input wire logic [3:0] rigidity_i,
  output nlg_pkg::nlg_notch_t notch_o
);

  logic [10:0] freq;
  logic cut;

  always_comb begin
    unique case (index_i)
      7'h05: freq = 11'h5ca;
      7'h06: freq = 11'h592;
      7'h07: freq = 11'h55c;
      7'h08: freq = 11'h527;
      7'h09: freq = 11'h4f5;
      7'h0a: freq = 11'h4c5;
      7'h0b: freq = 11'h496;
      7'h0c: freq = 11'h46a;
      7'h0d: freq = 11'h43f;
      7'h0e: freq = 11'h415;
      7'h0f: freq = 11'h3ed;
      7'h10: freq = 11'h3c7;
      7'h11: freq = 11'h3a2;
      7'h12: freq = 11'h37f;
      7'h13: freq = 11'h35d;
      7'h14: freq = 11'h33c;
      7'h15: freq = 11'h31c;
      7'h16: freq = 11'h2fe;
      7'h17: freq = 11'h2e1;
      7'h18: freq = 11'h2c5;
      7'h19: freq = 11'h2aa;
      7'h1a: freq = 11'h290;
      7'h1b: freq = 11'h277;
      7'h1c: freq = 11'h25f;
      7'h1d: freq = 11'h248;
      7'h1e: freq = 11'h232;
      7'h1f: freq = 11'h21c;
      7'h20: freq = 11'h208;
      7'h21: freq = 11'h1f4;
      7'h22: freq = 11'h1e1;
      7'h23: freq = 11'h1ce;
      7'h24: freq = 11'h1bd;
      7'h25: freq = 11'h1ac;
      7'h26: freq = 11'h19c;
      7'h27: freq = 11'h18c;
      7'h28: freq = 11'h17d;
      7'h29: freq = 11'h16e;
      7'h2a: freq = 11'h160;
      7'h2b: freq = 11'h153;
      7'h2c: freq = 11'h146;
      7'h2d: freq = 11'h13a;
      7'h2e: freq = 11'h12e;
      7'h2f: freq = 11'h122;
      7'h30: freq = 11'h117;
      7'h31: freq = 11'h10d;
      7'h32: freq = 11'h102;
      7'h33: freq = 11'h0f8;
      7'h34: freq = 11'h0ef;
      7'h35: freq = 11'h0e6;
      7'h36: freq = 11'h0dd;
      7'h37: freq = 11'h0d5;
      7'h38: freq = 11'h0cd;
      7'h39: freq = 11'h0c5;
      7'h3a: freq = 11'h0bd;
      7'h3b: freq = 11'h0b6;
      default: freq = 11'h000;
    endcase
  end

  // The stiffest machine settings drop the lowest notch frequencies.
  always_comb begin
    cut = 1'b0;
    if (index_i >= `NLG_IDX_F_LO && index_i <= `NLG_IDX_F_HI &&
        rigidity_i >= `NLG_RIG_F) begin
      cut = 1'b1;
    end
    if (index_i >= `NLG_IDX_E_LO && index_i <= `NLG_IDX_E_HI &&
        rigidity_i >= `NLG_RIG_E) begin
      cut = 1'b1;
    end
    if (index_i == `NLG_IDX_LAST && rigidity_i >= `NLG_RIG_D) begin
      cut = 1'b1;
    end
  end

  assign notch_o.enable = (freq != 11'h000) && !cut;
  assign notch_o.freq = freq;

endmodule
`default_nettype wire

// [verilog/nlg_top.sv]
// Purpose: Notch lookup and loop gain set selection with Wishbone access.
// Assumes: Classic Wishbone slave, 32-bit data, one 100 MHz clock.
// Notes: Written parameters wait in a staging copy until power-on.
`timescale 1ns/1ps
`default_nettype none
`include "nlg_cfg.svh"

module nlg_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic power_on_i,
  input wire logic gain_select_input_i,
  input wire logic switch_cond_met_i,
  input wire logic adaptive_enable_i,
  input wire logic [6:0] adaptive_table_index_i,
  input wire nlg_pkg::nlg_gain_set_t first_gain_set_i,
  input wire nlg_pkg::nlg_gain_set_t second_gain_set_i,
  output nlg_pkg::nlg_gain_set_t loop_gains_o,
  output logic gain_set2_o,
  output logic p_only_o,
  output nlg_pkg::nlg_notch_t notch_o
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic pwr_meta;
  logic pwr_sync;
  logic pwr_prev;
  logic gain_select_input_meta;
  logic gain_select_input_sync;
  logic power_edge;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pwr_meta <= 1'b0;
      pwr_sync <= 1'b0;
      pwr_prev <= 1'b0;
    end else begin
      pwr_meta <= power_on_i;
      pwr_sync <= pwr_meta;
      pwr_prev <= pwr_sync;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_select_input_meta <= 1'b0;
      gain_select_input_sync <= 1'b0;
    end else begin
      gain_select_input_meta <= gain_select_input_i;
      gain_select_input_sync <= gain_select_input_meta;
    end
  end

  assign power_edge = pwr_sync && !pwr_prev;

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  logic req;
  logic wr_ctrl;
  nlg_pkg::nlg_params_t staged;
  nlg_pkg::nlg_params_t active;
  logic [6:0] index_disp;

  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_ctrl = req && wb_we_i && wb_adr_i == `NLG_ADDR_CTRL;

  // The ack is registered, so every access answers one cycle later.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      wb_dat_o <= 32'h0000_0000;
      unique case (wb_adr_i)
        `NLG_ADDR_CTRL: begin
          wb_dat_o[`NLG_F_SW_EN] <= staged.sw_en;
          wb_dat_o[`NLG_F_COND_HI:`NLG_F_COND_LO] <= staged.cond;
          wb_dat_o[`NLG_F_RIG_HI:`NLG_F_RIG_LO] <= staged.rigidity;
        end
        `NLG_ADDR_STATUS: begin
          wb_dat_o[`NLG_F_SW_EN] <= active.sw_en;
          wb_dat_o[`NLG_F_COND_HI:`NLG_F_COND_LO] <= active.cond;
          wb_dat_o[`NLG_F_RIG_HI:`NLG_F_RIG_LO] <= active.rigidity;
          wb_dat_o[`NLG_F_GAIN2] <= gain_set2_o;
          wb_dat_o[`NLG_F_P_ONLY] <= p_only_o;
        end
        `NLG_ADDR_INDEX: begin
          wb_dat_o[6:0] <= index_disp;
        end
        `NLG_ADDR_NOTCH: begin
          wb_dat_o[10:0] <= notch_o.freq;
          wb_dat_o[`NLG_F_NOTCH_EN] <= notch_o.enable;
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Parameter staging and power-on apply
  // ----------------------------------------------------------------------
  // Out-of-range selector writes are dropped so the field keeps its value.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      staged.sw_en <= `NLG_RST_SW_EN;
      staged.cond <= `NLG_RST_COND;
      staged.rigidity <= `NLG_RST_RIG;
    end else if (wr_ctrl) begin
      if (wb_sel_i[0]) begin
        staged.sw_en <= wb_dat_i[`NLG_F_SW_EN];
        if (wb_dat_i[`NLG_F_COND_HI:`NLG_F_COND_LO] <= `NLG_COND_MAX) begin
          staged.cond <= wb_dat_i[`NLG_F_COND_HI:`NLG_F_COND_LO];
        end
      end
      if (wb_sel_i[1]) begin
        staged.rigidity <= wb_dat_i[`NLG_F_RIG_HI:`NLG_F_RIG_LO];
      end
    end
  end

  // Running values change only at power-on, never mid-motion.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active.sw_en <= `NLG_RST_SW_EN;
      active.cond <= `NLG_RST_COND;
      active.rigidity <= `NLG_RST_RIG;
    end else if (power_edge) begin
      active <= staged;
    end
  end

  // ----------------------------------------------------------------------
  // Adaptive index display and notch decode
  // ----------------------------------------------------------------------
  nlg_pkg::nlg_notch_t next_notch;

  // A disabled adaptive filter shows zero; values above 64 clamp.
  always_ff @(posedge clk_i) begin
    if (rst_i || !adaptive_enable_i) begin
      index_disp <= 7'h00;
    end else if (adaptive_table_index_i > `NLG_IDX_MAX) begin
      index_disp <= `NLG_IDX_MAX;
    end else begin
      index_disp <= adaptive_table_index_i;
    end
  end

  nlg_notch_rom u_rom (
    .index_i(index_disp),
    .rigidity_i(active.rigidity),
    .notch_o(next_notch)
  );

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      notch_o <= '0;
    end else begin
      notch_o <= next_notch;
    end
  end

  // ----------------------------------------------------------------------
  // Gain set selection
  // ----------------------------------------------------------------------
  logic next_gain2;

  // Selectors 3 and 5..10 use the loop's own condition detector.
  always_comb begin
    next_gain2 = 1'b0;
    if (active.sw_en) begin
      unique case (active.cond)
        `NLG_COND_GAIN1, `NLG_COND_GAIN1_B: next_gain2 = 1'b0;
        `NLG_COND_GAIN2: next_gain2 = 1'b1;
        `NLG_COND_INPUT: next_gain2 = gain_select_input_sync;
        default: next_gain2 = switch_cond_met_i;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gain_set2_o <= 1'b0;
      p_only_o <= 1'b0;
    end else begin
      gain_set2_o <= next_gain2;
      p_only_o <= !active.sw_en && gain_select_input_sync;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loop_gains_o <= '0;
    end else if (next_gain2) begin
      loop_gains_o <= second_gain_set_i;
    end else begin
      loop_gains_o <= first_gain_set_i;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_input_mode;
    active.sw_en && active.cond == `NLG_COND_INPUT;
  endsequence

  sequence s_gain_select_input_high;
    s_input_mode ##0 gain_select_input_sync;
  endsequence

  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_after_req: assert property (req |=> wb_ack_o)
    else $error("request not answered next cycle");
  a_cond_range: assert property (active.cond <= `NLG_COND_MAX)
    else $error("selector outside 0 to 10");
  a_apply_power: assert property (
    power_edge |=> active == $past(staged))
    else $error("staged values not applied at power-on");
  a_hold_active: assert property (!power_edge |=> $stable(active))
    else $error("running values changed without power-on");
  a_gain1_only: assert property (!active.sw_en |=> !gain_set2_o)
    else $error("gain set 2 used while switching disabled");
  a_p_only_input: assert property (
    !active.sw_en && gain_select_input_sync |=> p_only_o)
    else $error("P action not taken from gain select input");
  a_gain2_fixed: assert property (
    active.sw_en && active.cond == `NLG_COND_GAIN2 |=> gain_set2_o)
    else $error("selector 1 did not hold gain set 2");
  a_gain_select_input_follow: assert property (s_gain_select_input_high |=> gain_set2_o)
    else $error("selector 2 did not follow input");
  a_gains_pick: assert property (
    gain_set2_o |-> loop_gains_o == $past(second_gain_set_i))
    else $error("gain set 2 values not selected");
  a_index_zero: assert property (
    !adaptive_enable_i |=> index_disp == 7'h00)
    else $error("index shown while filter disabled");
  a_notch_low: assert property (
    index_disp < `NLG_IDX_FIRST |=> !notch_o.enable)
    else $error("notch enabled below index 5");
  a_notch_cut_f: assert property (
    index_disp >= `NLG_IDX_F_LO && index_disp <= `NLG_IDX_F_HI &&
    active.rigidity >= `NLG_RIG_F |=> !notch_o.enable)
    else $error("indices 49 to 53 not disabled at rigidity F");
  a_notch_cut_e: assert property (
    index_disp >= `NLG_IDX_E_LO && index_disp <= `NLG_IDX_E_HI &&
    active.rigidity >= `NLG_RIG_E |=> !notch_o.enable)
    else $error("indices 54 to 58 not disabled at rigidity E");
  a_notch_59: assert property (
    index_disp == `NLG_IDX_LAST && active.rigidity >= `NLG_RIG_D ##1
    $stable(active) |-> !notch_o.enable)
    else $error("index 59 not disabled at rigidity D");

endmodule
`default_nettype wire

// [testbench/nlg_top_tb.sv]
// Purpose: Self-checking bench for the notch lookup and gain select block.
// Assumes: Classic Wishbone register access, one 100 MHz clock.
// Notes: Reads queue their expected word; a monitor compares it on ack.
`timescale 1ns/1ps
`default_nettype none
`include "nlg_cfg.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch at %0t: got %h want %h", $time, a, b); end end

module nlg_top_tb;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pwr = 1'b0;
  logic gain_select_input = 1'b0, met = 1'b0, aen = 1'b0;
  logic [3:0] adr = 4'h0, sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, run;
  logic [6:0] idx = 7'h00, x;
  logic ack, gs2, ponly, on, b2, po, en;
  logic [3:0] c;
  logic [63:0] q[$];
  logic [63:0] e;
  nlg_pkg::nlg_gain_set_t g1 = '0, g2s = '0, gains;
  nlg_pkg::nlg_notch_t notch;
  int bad_count = 0, num_checks = 0, r, i, j, m, k;
  int frq[55] = '{1482, 1426, 1372, 1319, 1269, 1221, 1174, 1130, 1087,
    1045, 1005, 967, 930, 895, 861, 828, 796, 766, 737, 709, 682, 656,
    631, 607, 584, 562, 540, 520, 500, 481, 462, 445, 428, 412, 396, 381,
    366, 352, 339, 326, 314, 302, 290, 279, 269, 258, 248, 239, 230, 221,
    213, 205, 197, 189, 182};

  always #5 clk_i = ~clk_i;

  nlg_top i_nlg_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .power_on_i(pwr),
    .gain_select_input_i(gain_select_input), .switch_cond_met_i(met),
    .adaptive_enable_i(aen), .adaptive_table_index_i(idx),
    .first_gain_set_i(g1), .second_gain_set_i(g2s), .loop_gains_o(gains),
    .gain_set2_o(gs2), .p_only_o(ponly), .notch_o(notch));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  // Only reads leave a note. A write ack is skipped by its we level, since
  // the next read may already have queued its note at that same edge.
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0 && q.size() > 0) begin
      e = q.pop_front();
      `CHK(rdat & e[63:32], e[31:0])
    end
  end

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                    input logic [31:0] d, input logic [31:0] mk);
    if (!w) begin
      q.push_back({mk, d & mk});
    end
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    wdat <= w ? d : 32'h0;
    // No cycle budget here: a missing ack is left to the watchdog.
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // The pin has to fall again before another apply is recognised.
  task automatic pon();
    pwr <= 1'b1;
    repeat (6) @(posedge clk_i);
    pwr <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task automatic cfg(input logic e1, input logic [3:0] cc,
                     input logic [3:0] rr);
    logic [31:0] v;
    v = {20'h0, rr, cc, 3'h0, e1};
    wb(1'b1, `NLG_ADDR_CTRL, 4'hf, v, 32'h0);
    wb(1'b0, `NLG_ADDR_STATUS, 4'hf, run, 32'h0ff1);
    wb(1'b0, `NLG_ADDR_CTRL, 4'hf, v, 32'h0ff1);
    pon();
    run = v;
    wb(1'b0, `NLG_ADDR_STATUS, 4'hf, v, 32'h0ff1);
  endtask

  function automatic nlg_pkg::nlg_gain_set_t rnd();
    return nlg_pkg::nlg_gain_set_t'({$urandom(), $urandom(),
      16'($urandom())});
  endfunction

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    #1_000_000;
    bad_count++;
    finish_test();
  end

  initial begin
    void'($urandom(32'h20fe4788));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    run = 32'h0000_0201;
    wb(1'b0, `NLG_ADDR_CTRL, 4'hf, 32'h201, '1);
    wb(1'b0, `NLG_ADDR_STATUS, 4'hf, 32'h201, '1);
    wb(1'b1, `NLG_ADDR_STATUS, 4'hf, '1, 32'h0);
    wb(1'b0, `NLG_ADDR_STATUS, 4'hf, 32'h201, '1);
    wb(1'b0, 4'h2, 4'hf, 32'h0, '1);
    wb(1'b0, `NLG_ADDR_INDEX, 4'hf, 32'h0, '1);
    // Out-of-range selector is dropped, the other fields still land.
    wb(1'b1, `NLG_ADDR_CTRL, 4'hf, {20'h0, 4'h5, 4'(11 + $urandom % 5),
      4'h0}, 32'h0);
    wb(1'b0, `NLG_ADDR_CTRL, 4'hf, 32'h500, '1);
    wb(1'b1, `NLG_ADDR_CTRL, 4'h2, '1, 32'h0);
    wb(1'b0, `NLG_ADDR_CTRL, 4'hf, 32'hf00, '1);
    aen <= 1'b1;
    for (r = 0; r < 16; r++) begin
      cfg(1'b1, 4'h0, r[3:0]);
      for (i = 0; i < 66; i++) begin
        x = (i == 65) ? 7'(65 + $urandom % 63) : 7'(i);
        k = (i > 64) ? 64 : i;
        idx <= x;
        repeat (4) @(posedge clk_i);
        wb(1'b0, `NLG_ADDR_INDEX, 4'hf, 32'(k), 32'h7f);
        on = k >= 5 && k <= 59 && !(k >= 49 && k <= 53 && r >= 15) &&
          !(k >= 54 && k <= 58 && r >= 14) && !(k == 59 && r >= 13);
        wb(1'b0, `NLG_ADDR_NOTCH, 4'hf, on ? {15'h0, 1'b1, 5'h0,
          11'(frq[k - 5])} : 32'h0,
          on ? 32'h107ff : 32'h10000);
        `CHK(notch.enable, on)
      end
    end
    aen <= 1'b0;
    repeat (4) @(posedge clk_i);
    wb(1'b0, `NLG_ADDR_INDEX, 4'hf, 32'h0, 32'h7f);
    for (j = 0; j < 22; j++) begin
      en = (j >= 11);
      c = 4'(j % 11);
      cfg(en, c, 4'h2);
      g1 <= rnd();
      g2s <= rnd();
      for (m = 0; m < 4; m++) begin
        gain_select_input <= m[0];
        met <= m[1];
        repeat (6) @(posedge clk_i);
        b2 = en && (c == 1 || (c == 2 && m[0]) ||
          ((c == 3 || c > 4) && m[1]));
        po = !en && m[0];
        wb(1'b0, `NLG_ADDR_STATUS, 4'hf, {18'h0, po, b2, 4'h2, c, 3'h0, en},
          32'h3ff1);
        `CHK({ponly, gs2}, {po, b2})
        `CHK(gains, b2 ? g2s : g1)
      end
    end
    finish_test();
  end
endmodule
`default_nettype wire
